/* artpwm_timer.sv */
// artpwm_timer: 8-bit auto-reload pwm timer with 7-bit prescaler, four pwm
// outputs, two input captures and an apb register slave.
// assumes inputs synchronous to CLK_SYS_IN and an apb master on the same clock.
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module artpwm_timer
  import artpwm_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        CLK_EN_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // external clock and capture pins
  input  wire logic        EXT_CLK_IN,
  input  wire logic [1:0]  CAPTURE_INPUT_PIN_IN,
  // system
  input  wire logic        HALT_MODE_IN,
  // pwm pins
  output logic [3:0]       PWM_OUTPUT_PIN_OUT,
  output logic [3:0]       PWM_OUTPUT_PIN_OE_OUT,
  // interrupts and wakeup
  output logic             OVERFLOW_IRQ_OUT,
  output logic             CAPTURE_IRQ_OUT,
  output logic             WAKEUP_OUT
);
  // ==========================================================================
  // registers
  logic [7:0] csr_reg;       // force_reload and ovf bits unused here
  logic       overflow_flag_reg;
  logic [7:0] counter_reg;
  logic [6:0] prescaler_reg;
  logic [7:0] reload_value_reg;
  logic [7:0] pwm_control_reg; // [7:4] output enable, [3:0] polarity
  logic [7:0] duty_cycle_reg [ARTPWM_NPWM];
  logic [7:0] compare_shadow [ARTPWM_NPWM];
  logic [3:0] pwm_level_reg;
  logic [5:0] capture_control_status_reg;
  logic [7:0] capture_value_reg [ARTPWM_NCAP];
  logic [1:0] capture_flag_reg;
  logic       ext_clk_reg;

  // ==========================================================================
  // apb decode: zero wait states
  logic wr_en;
  logic rd_en;
  assign wr_en       = PSEL_IN & PENABLE_IN & PWRITE_IN & CLK_EN_IN;
  assign rd_en       = PSEL_IN & PENABLE_IN & ~PWRITE_IN & CLK_EN_IN;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = 1'b0;

  logic wr_csr, wr_car, rd_csr;
  logic [1:0] rd_icr;
  assign wr_csr    = wr_en && (PADDR_IN == ARTPWM_CSR_OFF);
  assign wr_car    = wr_en && (PADDR_IN == ARTPWM_CAR_OFF);
  assign rd_csr    = rd_en && (PADDR_IN == ARTPWM_CSR_OFF);
  assign rd_icr[0] = rd_en && (PADDR_IN == ARTPWM_ICR0_OFF);
  assign rd_icr[1] = rd_en && (PADDR_IN == ARTPWM_ICR1_OFF);

  logic       halt_sw_reg;   // software halt bit, ored with the halt input
  logic       halted;
  assign halted = HALT_MODE_IN | halt_sw_reg;

  // ==========================================================================
  // prescaler input: cpu clock or external clock rising edge
  logic ext_rise;
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ext_clk_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      ext_clk_reg <= EXT_CLK_IN;
    end
  end
  assign ext_rise = EXT_CLK_IN & ~ext_clk_reg;

  logic       run_en;
  logic       in_tick;
  logic       cnt_tick;
  logic [2:0] div_sel;
  logic [6:0] pre_mask;
  logic       init_load;
  logic       force_load;
  logic       ovf_event;

  assign run_en     = csr_reg[ARTPWM_CSR_TCE];
  assign in_tick    = csr_reg[ARTPWM_CSR_EXT_CLOCK_SELECT] ? ext_rise : ~halted;
  assign div_sel    = csr_reg[ARTPWM_CSR_CCH:ARTPWM_CSR_CCL];
  assign pre_mask   = ~({ARTPWM_PRE_W{1'b1}} << div_sel);
  // tick when the low n prescaler bits are all ones
  assign cnt_tick   = CLK_EN_IN & run_en & in_tick & ((prescaler_reg & pre_mask) == pre_mask);
  assign force_load = wr_csr & PWDATA_IN[ARTPWM_CSR_FORCE_RELOAD] & PWDATA_IN[ARTPWM_CSR_TCE];
  assign init_load  = force_load | wr_car;
  assign ovf_event  = cnt_tick & ~init_load & (counter_reg == ARTPWM_CNT_MAX);

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      prescaler_reg <= ARTPWM_PRE_RST;
    end else if (CLK_EN_IN) begin
      if (init_load) begin
        prescaler_reg <= ARTPWM_PRE_RST;
      end else if (run_en && in_tick) begin
        prescaler_reg <= prescaler_reg + ARTPWM_PRE_ONE;
      end
    end
  end

  // ==========================================================================
  // counter
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      counter_reg <= ARTPWM_RST8;
    end else if (CLK_EN_IN) begin
      if (wr_car) begin
        counter_reg <= PWDATA_IN[7:0];
      end else if (force_load) begin
        counter_reg <= reload_value_reg;
      end else if (ovf_event) begin
        counter_reg <= reload_value_reg;
      end else if (cnt_tick) begin
        counter_reg <= counter_reg + ARTPWM_CNT_ONE;
      end
    end
  end

  // ==========================================================================
  // control, status and configuration registers
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      csr_reg          <= ARTPWM_RST8;
      reload_value_reg <= ARTPWM_RST8;
      pwm_control_reg  <= ARTPWM_RST8;
      halt_sw_reg      <= 1'b0;
      capture_control_status_reg <= '0;
    end else if (wr_en) begin
      if (wr_csr) begin
        csr_reg <= {PWDATA_IN[7:3], 1'b0, PWDATA_IN[ARTPWM_CSR_OIE], 1'b0};
      end
      if (PADDR_IN == ARTPWM_ARR_OFF) begin
        reload_value_reg <= PWDATA_IN[7:0];
      end
      if (PADDR_IN == ARTPWM_PWM_CONTROL_REG_OFF) begin
        pwm_control_reg <= PWDATA_IN[7:0];
      end
      if (PADDR_IN == ARTPWM_ICCSR_OFF) begin
        capture_control_status_reg <= PWDATA_IN[5:0];
      end
      if (PADDR_IN == ARTPWM_SYS_OFF) begin
        halt_sw_reg <= PWDATA_IN[0];
      end
    end
  end

  // overflow flag: set wins over the read clear
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      overflow_flag_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (ovf_event) begin
        overflow_flag_reg <= 1'b1;
      end else if (rd_csr) begin
        overflow_flag_reg <= 1'b0;
      end
    end
  end
  assign OVERFLOW_IRQ_OUT = overflow_flag_reg & csr_reg[ARTPWM_CSR_OIE];

  // ==========================================================================
  // duty cycle registers, compare shadows and pwm levels
  generate
    for (genvar g = 0; g < ARTPWM_NPWM; g++) begin : g_pwm
      logic [7:0] dcr_off;
      assign dcr_off = ARTPWM_DCR0_OFF + 8'(4 * g);
      always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          duty_cycle_reg[g] <= ARTPWM_RST8;
          compare_shadow[g] <= ARTPWM_RST8;
          pwm_level_reg[g]  <= 1'b0;
        end else if (CLK_EN_IN) begin
          if (wr_en && (PADDR_IN == dcr_off)) begin
            duty_cycle_reg[g] <= PWDATA_IN[7:0];
          end
          if (ovf_event) begin
            compare_shadow[g] <= duty_cycle_reg[g];
          end
          if (!halted) begin
            if (ovf_event) begin
              pwm_level_reg[g] <= pwm_control_reg[g];
            end else if (cnt_tick && (counter_reg + ARTPWM_CNT_ONE == compare_shadow[g])) begin
              pwm_level_reg[g] <= ~pwm_control_reg[g];
            end
          end
        end
      end
    end
  endgenerate
  assign PWM_OUTPUT_PIN_OUT    = pwm_level_reg & pwm_control_reg[7:4];
  assign PWM_OUTPUT_PIN_OE_OUT = pwm_control_reg[7:4];

  // ==========================================================================
  // input capture
  logic [1:0] cap_edge;
  generate
    for (genvar c = 0; c < ARTPWM_NCAP; c++) begin : g_cap
      artpwm_edge u_edge (
        .CLK_SYS_IN  (CLK_SYS_IN),
        .RESET_N_IN  (RESET_N_IN),
        .CLK_EN_IN   (CLK_EN_IN),
        .SIG_IN      (CAPTURE_INPUT_PIN_IN[c]),
        .FALL_SEL_IN (capture_control_status_reg[ARTPWM_IC_CS + c]),
        .EDGE_OUT    (cap_edge[c])
      );
      always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          capture_value_reg[c] <= ARTPWM_RST8;
          capture_flag_reg[c]  <= 1'b0;
        end else if (CLK_EN_IN) begin
          if (cap_edge[c] && !capture_flag_reg[c]) begin
            capture_value_reg[c] <= counter_reg;
            capture_flag_reg[c]  <= 1'b1;
          end else if (rd_icr[c]) begin
            capture_flag_reg[c]  <= 1'b0;
          end
        end
      end
    end
  endgenerate
  // level stays high while any enabled flag is set
  assign CAPTURE_IRQ_OUT = |(capture_flag_reg & capture_control_status_reg[ARTPWM_IC_CIE +: ARTPWM_NCAP]);
  assign WAKEUP_OUT      = |(cap_edge & capture_control_status_reg[ARTPWM_IC_CIE +: ARTPWM_NCAP]);

  // ==========================================================================
  // read data register
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PRDATA_OUT <= '0;
    end else if (CLK_EN_IN && PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
      unique case (PADDR_IN)
        ARTPWM_CSR_OFF:   PRDATA_OUT <= {24'h000000, csr_reg[7:3], 1'b0,
                                         csr_reg[ARTPWM_CSR_OIE], overflow_flag_reg};
        ARTPWM_CAR_OFF:   PRDATA_OUT <= {24'h000000, counter_reg};
        ARTPWM_ARR_OFF:   PRDATA_OUT <= {24'h000000, reload_value_reg};
        ARTPWM_PWM_CONTROL_REG_OFF: PRDATA_OUT <= {24'h000000, pwm_control_reg};
        ARTPWM_DCR0_OFF:         PRDATA_OUT <= {24'h000000, duty_cycle_reg[0]};
        ARTPWM_DCR0_OFF + 8'h04: PRDATA_OUT <= {24'h000000, duty_cycle_reg[1]};
        ARTPWM_DCR0_OFF + 8'h08: PRDATA_OUT <= {24'h000000, duty_cycle_reg[2]};
        ARTPWM_DCR0_OFF + 8'h0C: PRDATA_OUT <= {24'h000000, duty_cycle_reg[3]};
        ARTPWM_ICCSR_OFF: PRDATA_OUT <= {26'h0000000, capture_control_status_reg[5:2], capture_flag_reg};
        ARTPWM_ICR0_OFF:  PRDATA_OUT <= {24'h000000, capture_value_reg[0]};
        ARTPWM_ICR1_OFF:  PRDATA_OUT <= {24'h000000, capture_value_reg[1]};
        ARTPWM_SYS_OFF:   PRDATA_OUT <= {31'h00000000, halt_sw_reg};
        default:          PRDATA_OUT <= '0;
      endcase
    end
  end

  // ==========================================================================
  // assertions
  sequence ovf_seq;
    ovf_event ##1 1'b1;
  endsequence

  reload_on_ovf_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (ovf_event && !wr_car && !force_load) |=> counter_reg == $past(reload_value_reg))
    else $error("counter not reloaded on overflow");
  ovf_flag_set_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    ovf_seq |-> overflow_flag_reg)
    else $error("overflow flag not set");
  ovf_rd_clear_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (rd_csr && !ovf_event) |=> !overflow_flag_reg)
    else $error("overflow flag not cleared by read");
  frozen_stop_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (!run_en && !wr_car && !force_load) |=> $stable(counter_reg) && $stable(prescaler_reg))
    else $error("counter moved while stopped");
  init_clear_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    init_load |=> prescaler_reg == ARTPWM_PRE_RST)
    else $error("prescaler not cleared on init");
  count_step_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (cnt_tick && !init_load && counter_reg != ARTPWM_CNT_MAX) |=> counter_reg == $past(counter_reg) + ARTPWM_CNT_ONE)
    else $error("counter did not step");
  capture_lock_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (capture_flag_reg[0] && !rd_icr[0]) |=> $stable(capture_value_reg[0]) && capture_flag_reg[0])
    else $error("capture register changed while locked");
  pwm_polarity_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (ovf_event && !halted && CLK_EN_IN) |=> pwm_level_reg == $past(pwm_control_reg[3:0]))
    else $error("pwm level not set to polarity at overflow");
  shadow_load_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    !ovf_event |=> compare_shadow[0] == $past(compare_shadow[0]))
    else $error("compare shadow changed outside overflow");
  shadow_load1_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    ovf_event |=> compare_shadow[1] == $past(duty_cycle_reg[1]))
    else $error("compare shadow not loaded at overflow");
  pre_continue_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    ovf_event |=> prescaler_reg == $past(prescaler_reg) + ARTPWM_PRE_ONE)
    else $error("prescaler disturbed by overflow");

  // force reload: write then counter holds the reload value
  sequence force_seq;
    force_load ##1 1'b1;
  endsequence

  force_reload_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    force_seq |-> counter_reg == $past(reload_value_reg))
    else $error("force reload did not load counter");
  car_load_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    wr_car |=> counter_reg == $past(PWDATA_IN[7:0]))
    else $error("counter write not taken");
  force_reload_read_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (CLK_EN_IN && PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == ARTPWM_CSR_OFF)
    |=> !PRDATA_OUT[ARTPWM_CSR_FORCE_RELOAD])
    else $error("force reload bit read back as one");
  ovf_sticky_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (overflow_flag_reg && !rd_csr) |=> overflow_flag_reg)
    else $error("overflow flag lost without read");
  halt_freeze_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    halted |=> $stable(pwm_level_reg))
    else $error("pwm level moved in halt");
  clken_freeze_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    !CLK_EN_IN |=> $stable(counter_reg) && $stable(prescaler_reg)
                   && $stable(overflow_flag_reg) && $stable(capture_flag_reg))
    else $error("state moved with clock enable low");
  pwm_match_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (cnt_tick && !ovf_event && !halted && (counter_reg + ARTPWM_CNT_ONE == compare_shadow[0]))
    |=> pwm_level_reg[0] == ~$past(pwm_control_reg[0]))
    else $error("pwm level not restored at compare match");
  capture_take_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (cap_edge[0] && !capture_flag_reg[0])
    |=> capture_flag_reg[0] && capture_value_reg[0] == $past(counter_reg))
    else $error("capture did not latch counter");
  capture_clear_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (rd_icr[0] && capture_flag_reg[0]) |=> !capture_flag_reg[0])
    else $error("capture flag not cleared by read");
  capture_lock1_a: assert property (@(posedge CLK_SYS_IN) disable iff (!RESET_N_IN)
    (capture_flag_reg[1] && !rd_icr[1]) |=> $stable(capture_value_reg[1]) && capture_flag_reg[1])
    else $error("capture register changed while locked");
endmodule // artpwm_timer

/* artpwm_pkg.sv */
// artpwm_pkg: register offsets, field positions and reset values of the
// auto-reload pwm timer; assumes a 32-bit apb with word-aligned registers.
package artpwm_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] ARTPWM_CSR_OFF   = 8'h00; // timer_control_status_reg
  localparam logic [7:0] ARTPWM_CAR_OFF   = 8'h04; // counter_access_reg
  localparam logic [7:0] ARTPWM_ARR_OFF   = 8'h08; // reload_value_reg
  localparam logic [7:0] ARTPWM_PWM_CONTROL_REG_OFF = 8'h0C; // pwm_control_reg
  localparam logic [7:0] ARTPWM_DCR0_OFF  = 8'h10; // duty_cycle_reg 0..3 at +4
  localparam logic [7:0] ARTPWM_ICCSR_OFF = 8'h20; // capture_control_status_reg
  localparam logic [7:0] ARTPWM_ICR0_OFF  = 8'h24; // capture_value_reg 0
  localparam logic [7:0] ARTPWM_ICR1_OFF  = 8'h28; // capture_value_reg 1
  localparam logic [7:0] ARTPWM_SYS_OFF   = 8'h2C; // halt mode control
  // ==========================================================================
  // timer_control_status_reg fields
  localparam int ARTPWM_CSR_EXT_CLOCK_SELECT = 7;
  localparam int ARTPWM_CSR_CCH  = 6;
  localparam int ARTPWM_CSR_CCL  = 4;
  localparam int ARTPWM_CSR_TCE  = 3;
  localparam int ARTPWM_CSR_FORCE_RELOAD = 2;
  localparam int ARTPWM_CSR_OIE  = 1;
  localparam int ARTPWM_CSR_OVF  = 0;
  // capture_control_status_reg fields: edge select [5:4], irq enable [3:2], flag [1:0]
  localparam int ARTPWM_IC_CS  = 4;
  localparam int ARTPWM_IC_CIE = 2;
  localparam int ARTPWM_IC_CF  = 0;
  // ==========================================================================
  // sizes and reset values
  localparam int         ARTPWM_NPWM     = 4;
  localparam int         ARTPWM_NCAP     = 2;
  localparam int         ARTPWM_PRE_W    = 7;
  localparam logic [7:0] ARTPWM_RST8     = 8'h00;
  localparam logic [7:0] ARTPWM_CNT_MAX  = 8'hFF;
  localparam logic [6:0] ARTPWM_PRE_RST  = 7'h00;
  localparam logic [6:0] ARTPWM_PRE_ONE  = 7'h01;
  localparam logic [7:0] ARTPWM_CNT_ONE  = 8'h01;
endpackage : artpwm_pkg

/* artpwm_edge.sv */
// artpwm_edge: synchronous edge detector for one input, rising or falling.
// assumes the input is already synchronous to the clock.
`timescale 1ns/1ns
module artpwm_edge (
  // clock and reset
  input  wire logic CLK_SYS_IN,
  input  wire logic RESET_N_IN,
  input  wire logic CLK_EN_IN,
  // signal
  input  wire logic SIG_IN,
  input  wire logic FALL_SEL_IN,
  output logic      EDGE_OUT
);
  logic sig_reg;

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      sig_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      sig_reg <= SIG_IN;
    end
  end

  // selected transition, qualified by the clock enable
  assign EDGE_OUT = CLK_EN_IN & (FALL_SEL_IN ? (sig_reg & ~SIG_IN) : (~sig_reg & SIG_IN));
endmodule // artpwm_edge

/* tb_artpwm_timer.sv */
// tb_artpwm_timer: self-checking bench for the auto-reload pwm timer.
// assumes the timer answers apb with zero wait states and one cpu clock.
`timescale 1ns/1ns
module tb_artpwm_timer;
  import artpwm_pkg::*;
  // ==========================================================================
  // signals
  logic        clk_sys;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        ext_clk;
  logic [1:0]  cap_pin;
  logic        halt;
  logic        clk_en;
  wire  [31:0] prdata;
  wire         pready;
  wire  [3:0]  pwm;
  wire  [3:0]  pwm_oe;
  wire         ovf_irq;
  wire         cap_irq;
  wire         wakeup;
  wire         pslverr;
  wire  [6:0]  mon;
  int          err_total;
  int          num_checks;
  logic [31:0] q;
  logic [31:0] c;
  logic [31:0] v;
  int          hi;
  int          lo;
  int          flips;
  logic        last;
  logic [7:0]  rst_offs [5];
  assign mon = {wakeup, cap_irq, ovf_irq, pwm};
  // ==========================================================================
  // device
  artpwm_timer dut (
    .CLK_SYS_IN(clk_sys), .RESET_N_IN(reset_n), .CLK_EN_IN(clk_en),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .EXT_CLK_IN(ext_clk), .CAPTURE_INPUT_PIN_IN(cap_pin), .HALT_MODE_IN(halt),
    .PWM_OUTPUT_PIN_OUT(pwm), .PWM_OUTPUT_PIN_OE_OUT(pwm_oe),
    .OVERFLOW_IRQ_OUT(ovf_irq), .CAPTURE_IRQ_OUT(cap_irq), .WAKEUP_OUT(wakeup)
  );
  always #5 clk_sys = ~clk_sys;
  // ==========================================================================
  // tasks
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wait_lvl(input int i, input logic lv, input int lim);
    int k;
    k = 0;
    while (mon[i] !== lv && k < lim) begin
      @(posedge clk_sys);
      k++;
    end
    if (k == lim) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, mon[i], lv);
      summarize();
    end
  endtask
  // one apb transfer; a clock edge passes after release so calls may follow
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rq = prdata;
    psel <= 1'b0; penable <= 1'b0;
    if (k == 50) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, pready, 1'b1);
      summarize();
    end else begin
      @(posedge clk_sys);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dq;
    apb(1'b1, a, d, dq);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] rq);
    apb(1'b0, a, 32'h0, rq);
  endtask
  task automatic ext_pulse();
    ext_clk <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ext_clk <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic meas(input int i, input logic lv, output int h, output int l);
    wait_lvl(i, !lv, 5000);
    wait_lvl(i, lv, 5000);
    h = 0;
    while (mon[i] === lv && h < 5000) begin @(posedge clk_sys); h++; end
    l = 0;
    while (mon[i] !== lv && l < 5000) begin @(posedge clk_sys); l++; end
    if (h == 5000 || l == 5000) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, h, l);
      summarize();
    end
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    clk_sys = 1'b0; reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; ext_clk = 1'b0; cap_pin = 2'b00; halt = 1'b0;
    clk_en = 1'b1;
    err_total = 0; num_checks = 0;
    rst_offs = '{ARTPWM_CSR_OFF, ARTPWM_CAR_OFF, ARTPWM_ARR_OFF, ARTPWM_PWM_CONTROL_REG_OFF, ARTPWM_ICCSR_OFF};
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    foreach (rst_offs[i]) begin
      rd(rst_offs[i], q); chk(q, 32'h0);
    end
    chk(32'({pslverr, pready, pwm_oe, pwm}), 32'h100);
    wr(8'h30, 32'hFF); rd(8'h30, q); chk(q, 32'h0);
    // stopped counter holds a written value
    wr(ARTPWM_CAR_OFF, 32'h37); repeat (20) @(posedge clk_sys);
    rd(ARTPWM_CAR_OFF, q); chk(q, 32'h37);
    // overflow flag, interrupt and read clear
    wr(ARTPWM_ARR_OFF, 32'hC0); wr(ARTPWM_CAR_OFF, 32'hFA); wr(ARTPWM_CSR_OFF, 32'h0A);
    wait_lvl(4, 1'b1, 50);
    rd(ARTPWM_CSR_OFF, q); chk(q, 32'h0B);
    chk(32'(ovf_irq), 32'h0);
    rd(ARTPWM_CSR_OFF, q); chk(q, 32'h0A);
    rd(ARTPWM_CAR_OFF, q); chk(32'(q[7:0] >= 8'hC0 && q[7:0] < 8'hD0), 32'h1);
    // event counting on the external clock
    wr(ARTPWM_CSR_OFF, 32'h0); wr(ARTPWM_ARR_OFF, 32'hFD); wr(ARTPWM_CSR_OFF, 32'h8C);
    rd(ARTPWM_CSR_OFF, q); chk(q, 32'h88);
    repeat (10) @(posedge clk_sys);
    rd(ARTPWM_CAR_OFF, q); chk(q, 32'hFD);
    ext_pulse(); ext_pulse();
    rd(ARTPWM_CSR_OFF, q); chk(32'(q[0]), 32'h0);
    rd(ARTPWM_CAR_OFF, q); chk(q, 32'hFF);
    ext_pulse();
    rd(ARTPWM_CSR_OFF, q); chk(32'(q[0]), 32'h1);
    rd(ARTPWM_CAR_OFF, q); chk(q, 32'hFD);
    // external clock: run enable cleared before halt, so edges are not counted
    wr(ARTPWM_CSR_OFF, 32'h80);
    halt <= 1'b1;
    ext_pulse();
    ext_pulse();
    halt <= 1'b0;
    rd(ARTPWM_CAR_OFF, q);
    chk(q, 32'hFD);
    // pwm period and duty for every divider tap
    wr(ARTPWM_ARR_OFF, 32'hF0); wr(ARTPWM_DCR0_OFF, 32'hF4); wr(ARTPWM_DCR0_OFF + 8'h04, 32'hF4);
    wr(ARTPWM_PWM_CONTROL_REG_OFF, 32'h31);
    chk(32'({pwm[3:2], pwm_oe}), 32'h03);
    for (int n = 0; n < 8; n++) begin
      wr(ARTPWM_CSR_OFF, 32'(8'h08 | (n << 4)));
      meas(0, 1'b1, hi, lo);
      chk(32'(hi), 32'(4 << n));
      chk(32'(hi + lo), 32'(16 << n));
      meas(1, 1'b0, hi, lo);
      chk(32'(hi), 32'(4 << n));
      chk(32'(lo), 32'(12 << n));
    end
    // halt freezes pwm
    wr(ARTPWM_CSR_OFF, 32'h08);
    halt <= 1'b1; flips = 0;
    @(posedge clk_sys); last = pwm[0];
    repeat (100) begin
      @(posedge clk_sys);
      if (pwm[0] !== last) flips++;
    end
    chk(32'(flips), 32'h0);
    halt <= 1'b0;
    meas(0, 1'b1, hi, lo); chk(32'(hi), 32'h4);
    // captures: lock until read, interrupt pending, falling edge select
    wr(ARTPWM_ARR_OFF, 32'h0); wr(ARTPWM_CAR_OFF, 32'h10); wr(ARTPWM_ICCSR_OFF, 32'h24);
    cap_pin[1] <= 1'b1;
    rd(ARTPWM_CAR_OFF, c);
    cap_pin[0] <= 1'b1;
    wait_lvl(6, 1'b1, 4);
    wait_lvl(5, 1'b1, 5);
    rd(ARTPWM_ICCSR_OFF, q); chk(q, 32'h25);
    cap_pin[0] <= 1'b0; repeat (30) @(posedge clk_sys);
    cap_pin[0] <= 1'b1; repeat (5) @(posedge clk_sys);
    chk(32'(cap_irq), 32'h1);
    rd(ARTPWM_ICR0_OFF, v); chk(32'(v[7:0] - c[7:0]), 32'h3);
    rd(ARTPWM_ICR0_OFF, q); chk(q, v);
    chk(32'(cap_irq), 32'h0);
    rd(ARTPWM_ICCSR_OFF, q); chk(q, 32'h24);
    cap_pin[1] <= 1'b0; repeat (4) @(posedge clk_sys);
    rd(ARTPWM_ICCSR_OFF, q); chk(q, 32'h26);
    chk(32'(cap_irq), 32'h0);
    // clock enable low freezes the running counter
    wr(ARTPWM_CAR_OFF, 32'h10);
    rd(ARTPWM_CAR_OFF, c);
    clk_en <= 1'b0;
    repeat (20) @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(ARTPWM_CAR_OFF, q);
    chk(32'(q[7:0] - c[7:0]), 32'h3);
    // software halt bit stops the cpu clock tick
    wr(ARTPWM_SYS_OFF, 32'h1);
    rd(ARTPWM_CAR_OFF, c);
    rd(ARTPWM_SYS_OFF, q);
    chk(q, 32'h1);
    rd(ARTPWM_CAR_OFF, q);
    chk(q, c);
    wr(ARTPWM_SYS_OFF, 32'h0);
    summarize();
  end
endmodule // tb_artpwm_timer
